// *** core/dual_process_alarm.sv ***
`include "dual_process_alarm_consts.svh"
module dual_process_alarm
  import dual_process_alarm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_NS / `CLK_NS
) (
  input  wire logic               clk,     // 50 MHz
  input  wire logic               rst_n,   // async, active low
  input  wire apb_req_t           apb_req, // apb request
  output apb_rsp_t                apb_rsp, // apb answer
  input  wire logic signed [15:0] value,   // displayed value
  input  wire btn_t               btn,     // one-cycle key presses
  output logic [1:0]              sw,      // switch closed per channel
  output logic [1:0]              ann,     // annunciators
  output view_t                   view     // display selection
);

  st_t q;
  st_t n;

  // register decode, shared by read and write paths
  function automatic reg_t reg_of(input logic [7:0] a);
    unique case (a)
      `A_CTRL:   reg_of = R_CTRL;
      `A_SP1:    reg_of = R_SP1;
      `A_SP2:    reg_of = R_SP2;
      `A_HYS:    reg_of = R_HYS;
      `A_WAIT:   reg_of = R_WAIT;
      `A_QUIET:  reg_of = R_QUIET;
      `A_CODE:   reg_of = R_CODE;
      `A_SPAN:   reg_of = R_SPAN;
      `A_STATUS: reg_of = R_STATUS;
      default:   reg_of = R_NONE;
    endcase
  endfunction : reg_of

  // one nibble of the edit value stepped up or down, wrapping
  function automatic logic [15:0] nib_step(input logic [15:0] v,
                                           input logic [1:0]  d,
                                           input logic        up);
    logic [3:0] x;
    x = v[d*4 +: 4];
    x = up ? x + 4'h1 : x - 4'h1;
    nib_step = v;
    nib_step[d*4 +: 4] = x;
  endfunction : nib_step

  function automatic logic in_span(input logic signed [15:0] v,
                                   input logic signed [15:0] lo,
                                   input logic signed [15:0] hi);
    in_span = (v >= lo) && (v <= hi);
  endfunction : in_span

  logic               accept;
  logic               any_btn;
  logic signed [16:0] v17;
  logic signed [16:0] lo17;
  logic signed [16:0] hi17;
  logic               cond_d;
  logic [1:0]         alt_on;
  reg_t               rsel;

  // whole next state
  always_comb begin
    n = q;
    accept = 1'b0;
    any_btn = btn.sel | btn.up | btn.dn | btn.ext;
    v17 = {value[15], value};
    lo17 = '0;
    hi17 = '0;
    cond_d = 1'b0;
    alt_on = '0;
    rsel = reg_of(apb_req.paddr);
    n.tick = 1'b0;
    n.rsp.pready = 1'b0;
    n.rsp.pslverr = 1'b0;

    // one second timebase
    if (q.tick_cnt == 26'(TICK_CYCLES - 1)) begin
      n.tick_cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.tick_cnt = q.tick_cnt + 26'h1;
    end
    if (q.tick) begin
      n.phase = ~q.phase;
      n.seq = q.seq + 2'h1;
    end

    // operator menu reached from display mode
    unique case (q.view.menu)
      M_DISP: begin
        if (btn.sel && btn.up) begin
          if (q.acc_on) begin                                 // RQ22
            n.view.menu = (q.code == 16'h0000) ? M_PICK       // RQ17
                                                 : M_CODE;    // RQ15
            n.view.edit = '0;
            n.view.dig = '0;
            n.view.which = 1'b0;
            n.idle = '0;
          end
        end else if (btn.sel) begin
          accept = 1'b1;                                      // RQ10
        end
      end
      M_CODE, M_EDIT: begin
        if (btn.up) begin
          n.view.edit = nib_step(q.view.edit, q.view.dig, 1'b1); // RQ20
        end else if (btn.dn) begin
          n.view.edit = nib_step(q.view.edit, q.view.dig, 1'b0); // RQ20
        end else if (btn.sel) begin
          n.view.dig = q.view.dig + 2'h1;                     // RQ20
        end else if (btn.ext) begin
          if (q.view.menu == M_CODE) begin
            // wrong code drops straight back to display mode
            n.view.menu = (q.view.edit == q.code) ? M_PICK : M_DISP; // RQ16
          end else begin
            if (in_span(q.view.edit, q.span_lo, q.span_hi)) begin  // RQ2
              n.ch[q.view.which].sp = q.view.edit;            // RQ19
            end
            n.view.menu = M_PICK;
          end
        end
      end
      M_PICK: begin
        if (btn.up || btn.dn) begin
          n.view.which = ~q.view.which;                       // RQ21
        end else if (btn.sel) begin
          n.view.edit = q.ch[q.view.which].sp;
          n.view.dig = '0;
          n.view.menu = M_EDIT;
        end else if (btn.ext) begin
          n.view.menu = M_DISP;                               // RQ21
        end
      end
    endcase

    // idle keys for 20 s abandon the menu
    if (q.view.menu != M_DISP) begin
      if (any_btn) begin
        n.idle = '0;
      end else if (q.tick) begin
        if (q.idle == 5'(`IDLE_S - 1)) begin
          n.view.menu = M_DISP;
        end else begin
          n.idle = q.idle + 5'h1;
        end
      end
    end

    // both channels share one behaviour, own parameters
    for (int i = 0; i < 2; i++) begin                         // RQ24
      lo17 = {q.ch[i].sp[15], q.ch[i].sp} - $signed({1'b0, q.ch[i].hys});
      hi17 = {q.ch[i].sp[15], q.ch[i].sp} + $signed({1'b0, q.ch[i].hys});
      if (q.ch[i].cond) begin
        cond_d = q.ch[i].high ? (v17 >= lo17)                 // RQ5
                              : (v17 <= hi17);                // RQ25
      end else begin
        cond_d = q.ch[i].high ? (value >= q.ch[i].sp)         // RQ3
                              : (value <= q.ch[i].sp);        // RQ23
      end
      if (!q.ch[i].en) begin
        // configuration fields are left as they are
        n.ch[i].cond = 1'b0;                                  // RQ1
        n.ch[i].act = 1'b0;                                   // RQ26
        n.ch[i].quiet_interval = 1'b0;
        n.ch[i].dly = '0;
        n.ch[i].scnt = '0;
      end else begin
        n.ch[i].cond = cond_d;
        if (!cond_d) begin
          n.ch[i].act = 1'b0;
          n.ch[i].quiet_interval = 1'b0;
          n.ch[i].dly = '0;                                   // RQ7
          n.ch[i].scnt = '0;
        end else if (q.ch[i].quiet_interval) begin
          if (q.tick) begin
            if (q.ch[i].scnt <= 12'h001) begin
              n.ch[i].quiet_interval = 1'b0;
              n.ch[i].act = 1'b1;                             // RQ11
            end else begin
              n.ch[i].scnt = q.ch[i].scnt - 12'h001;
            end
          end
        end else if (!q.ch[i].act) begin
          if (q.ch[i].wait_s == 12'h000) begin
            n.ch[i].act = 1'b1;                               // RQ6
          end else if (q.tick) begin
            if (q.ch[i].dly + 12'h001 >= q.ch[i].wait_s) begin
              n.ch[i].act = 1'b1;                             // RQ7
              n.ch[i].dly = '0;
            end else begin
              n.ch[i].dly = q.ch[i].dly + 12'h001;
            end
          end
        end else if (accept && q.ch[i].quiet_s != 12'h000) begin
          n.ch[i].act = 1'b0;                                 // RQ11
          n.ch[i].quiet_interval = 1'b1;
          n.ch[i].scnt = q.ch[i].quiet_s;
        end
      end
      // steady when asserted, blinking while waiting or quiet
      n.ch[i].ann = n.ch[i].act
                  | (n.ch[i].cond & n.phase);                 // RQ8 RQ12
      n.ch[i].sw = n.ch[i].act ^ n.ch[i].nc;                  // RQ4
      alt_on[i] = q.ch[i].alt & q.ch[i].act;                  // RQ9 RQ13
    end

    // value on even seconds, tags on odd ones
    if (!q.seq[0] || alt_on == 2'b00) begin
      n.view.tag = 2'h0;
    end else if (alt_on == 2'b11) begin
      n.view.tag = q.seq[1] ? 2'h2 : 2'h1;                    // RQ14
    end else begin
      n.view.tag = alt_on[0] ? 2'h1 : 2'h2;                   // RQ14
    end

    // apb access phase: answer one cycle later
    if (apb_req.psel && apb_req.penable && !q.rsp.pready) begin
      n.rsp.pready = 1'b1;
      n.rsp.prdata = '0;
      if (apb_req.pwrite) begin
        unique case (rsel)
          R_CTRL: begin
            for (int i = 0; i < 2; i++) begin
              n.ch[i].en = apb_req.pwdata[4*i];
              n.ch[i].high = apb_req.pwdata[4*i+1];           // RQ3
              n.ch[i].nc = apb_req.pwdata[4*i+2];
              n.ch[i].alt = apb_req.pwdata[4*i+3];
            end
            n.acc_on = apb_req.pwdata[`CTRL_ACC_BIT];         // RQ22
          end
          R_SP1, R_SP2: begin
            if (in_span(apb_req.pwdata[15:0], q.span_lo, q.span_hi)) begin
              n.ch[rsel == R_SP2].sp = apb_req.pwdata[15:0];  // RQ2
            end else begin
              n.rsp.pslverr = 1'b1;
            end
          end
          R_HYS: begin
            n.ch[0].hys = apb_req.pwdata[15:0];
            n.ch[1].hys = apb_req.pwdata[31:16];
          end
          R_WAIT, R_QUIET: begin
            // figures past 3600 s are refused whole
            if (apb_req.pwdata[11:0] > `MAX_SECONDS ||
                apb_req.pwdata[27:16] > `MAX_SECONDS) begin
              n.rsp.pslverr = 1'b1;                           // RQ6 RQ10
            end else if (rsel == R_WAIT) begin
              n.ch[0].wait_s = apb_req.pwdata[11:0];
              n.ch[1].wait_s = apb_req.pwdata[27:16];
            end else begin
              n.ch[0].quiet_s = apb_req.pwdata[11:0];
              n.ch[1].quiet_s = apb_req.pwdata[27:16];
            end
          end
          R_CODE: n.code = apb_req.pwdata[15:0];              // RQ16
          R_SPAN: begin
            n.span_lo = apb_req.pwdata[15:0];
            n.span_hi = apb_req.pwdata[31:16];
          end
          R_STATUS: ;
          R_NONE: n.rsp.pslverr = 1'b1;
        endcase
      end else begin
        unique case (rsel)
          R_CTRL: begin
            for (int i = 0; i < 2; i++) begin
              n.rsp.prdata[4*i +: 4] = {q.ch[i].alt, q.ch[i].nc,
                                        q.ch[i].high, q.ch[i].en};
            end
            n.rsp.prdata[`CTRL_ACC_BIT] = q.acc_on;
          end
          R_SP1:   n.rsp.prdata[15:0] = q.ch[0].sp;
          R_SP2:   n.rsp.prdata[15:0] = q.ch[1].sp;
          R_HYS:   n.rsp.prdata = {q.ch[1].hys, q.ch[0].hys};
          R_WAIT:  n.rsp.prdata = {4'h0, q.ch[1].wait_s,
                                   4'h0, q.ch[0].wait_s};
          R_QUIET: n.rsp.prdata = {4'h0, q.ch[1].quiet_s,
                                   4'h0, q.ch[0].quiet_s};
          R_CODE:  n.rsp.prdata[15:0] = q.code;
          R_SPAN:  n.rsp.prdata = {q.span_hi, q.span_lo};
          R_STATUS: n.rsp.prdata[7:0] = {q.view.menu, q.ch[1].quiet_interval,
                                         q.ch[0].quiet_interval, q.ch[1].act,
                                         q.ch[0].act, q.ch[1].cond,
                                         q.ch[0].cond};
          R_NONE:  n.rsp.pslverr = 1'b1;
        endcase
      end
    end
  end

  // register the whole state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.view.menu <= M_DISP;
      q.acc_on <= 1'b0;                                       // RQ18
      q.code <= `CODE_RST;                                    // RQ18
      q.span_lo <= `SPAN_LO_RST;
      q.span_hi <= `SPAN_HI_RST;
    end else begin
      q <= n;
    end
  end

  assign apb_rsp = q.rsp;
  assign view = q.view;
  assign sw = {q.ch[1].sw, q.ch[0].sw};
  assign ann = {q.ch[1].ann, q.ch[0].ann};

endmodule : dual_process_alarm

// *** inc/dual_process_alarm_consts.svh ***
// Functional notes
// [RQ1] Per-channel enable suspends alarms; stored parameters stay untouched.
// [RQ2] Setpoints accepted only inside the programmed loop-span display limits.
// [RQ3] Each channel selects high or low alarm independently.
// [RQ4] Output sense: open or closed when not alarmed, inverted in alarm.
// [RQ5] High alarm clears only below setpoint minus hysteresis (display units).
// [RQ6] Activation wait 0..3600 whole seconds; zero means no delay.
// [RQ7] Output asserts after uninterrupted condition for the wait; breaks restart.
// [RQ8] Annunciator flashes during the wait, steady once output asserted.
// [RQ9] Alternate display starts only after the output is asserted.
// [RQ10] Quiet interval 0..3600 s; non-zero makes select an accept key.
// [RQ11] Accept drops output for quiet interval; re-asserts if still alarmed.
// [RQ12] Annunciator flashes during quiet interval until expiry or clear.
// [RQ13] Alternate display suppressed in quiet interval; only when asserted.
// [RQ14] Alternate value and tags; both tags in turn when both asserted.
// [RQ15] Select plus up in display mode opens the setpoint menu.
// [RQ16] Separate four-digit operator pass code guards display-mode setpoints.
// [RQ17] All-zero pass code skips the code prompt.
// [RQ18] Reset: operator level menu disabled, pass code zero.
// [RQ19] Choice items shown on select, changed by up/down, stored on exit.
// [RQ20] Numeric items: active digit edited by up/down, select advances, exit.
// [RQ21] Up/down moves between the two items of the submenu; exit leaves.
// [RQ22] Menu disabled: chord ignored, setpoints only via configuration.
// [RQ23] Condition arises when display reaches setpoint in the alarm direction.
// [RQ24] Second channel identical with independent parameters.
// [RQ25] Low alarm clears only above setpoint plus hysteresis.
// [RQ26] Disabled channel: output non-alarm, wait and quiet timers cleared.
`ifndef DUAL_PROCESS_ALARM_CONSTS_SVH
`define DUAL_PROCESS_ALARM_CONSTS_SVH
`define CLK_NS       20
`define TICK_NS      1000000000
`define IDLE_S       20
`define MAX_SECONDS  12'hE10
`define A_CTRL       8'h00
`define A_SP1        8'h04
`define A_SP2        8'h08
`define A_HYS        8'h0C
`define A_WAIT       8'h10
`define A_QUIET      8'h14
`define A_CODE       8'h18
`define A_SPAN       8'h1C
`define A_STATUS     8'h20
`define CTRL_ACC_BIT 8
`define SPAN_LO_RST  16'h8000
`define SPAN_HI_RST  16'h7FFF
`define CODE_RST     16'h0000
`endif

// *** inc/dual_process_alarm_pkg.sv ***
package dual_process_alarm_pkg;
  typedef enum logic [1:0] {M_DISP, M_CODE, M_PICK, M_EDIT} menu_t;
  typedef enum logic [3:0] {
    R_CTRL, R_SP1, R_SP2, R_HYS, R_WAIT, R_QUIET, R_CODE, R_SPAN, R_STATUS,
    R_NONE
  } reg_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;
  typedef struct packed {
    logic sel;
    logic up;
    logic dn;
    logic ext;
  } btn_t;
  typedef struct packed {
    menu_t       menu;
    logic        which;
    logic [15:0] edit;
    logic [1:0]  dig;
    logic [1:0]  tag;
  } view_t;
  typedef struct packed {
    logic               en;
    logic               high;
    logic               nc;
    logic               alt;
    logic signed [15:0] sp;
    logic [15:0]        hys;
    logic [11:0]        wait_s;
    logic [11:0]        quiet_s;
    logic               cond;
    logic               act;
    logic               quiet_interval;
    logic [11:0]        dly;
    logic [11:0]        scnt;
    logic               ann;
    logic               sw;
  } ch_t;
  typedef struct packed {
    ch_t [1:0]          ch;
    logic               acc_on;
    logic [15:0]        code;
    logic signed [15:0] span_lo;
    logic signed [15:0] span_hi;
    logic [25:0]        tick_cnt;
    logic               tick;
    logic               phase;
    logic [1:0]         seq;
    logic [4:0]         idle;
    view_t              view;
    apb_rsp_t           rsp;
  } st_t;
endpackage : dual_process_alarm_pkg

// *** verification/alarm_asserts.sv ***
module alarm_asserts
  import dual_process_alarm_pkg::*;
(
  input wire logic     clk,     // clock
  input wire logic     rst_n,   // reset, active low
  input wire apb_req_t apb_req, // register request
  input wire apb_rsp_t apb_rsp, // register answer
  input wire btn_t     btn,     // key pulses
  input wire logic [1:0] sw,    // switch outputs
  input wire logic [1:0] ann,   // annunciators
  input wire view_t    view     // display selection
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ctrl_q;
  logic [15:0] code_q;
  logic [1:0]  alm_q;
  logic        wr;
  logic        chord;
  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite
              & ~apb_rsp.pready;
  assign chord = btn.sel & btn.up;
  // shadow of control and pass code; these writes are never refused
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '0;
      code_q <= '0;
      alm_q  <= '0;
    end else begin
      if (wr && apb_req.paddr == 8'h00) ctrl_q <= apb_req.pwdata[15:0];
      if (wr && apb_req.paddr == 8'h18) code_q <= apb_req.pwdata[15:0];
      alm_q <= sw ^ {ctrl_q[6], ctrl_q[2]};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_CHORD_OFF: assert property (
    chord && !ctrl_q[8] && view.menu == M_DISP |=> view.menu == M_DISP)
    else $error("chord opened a menu while access is off");
  AST_CHORD_FREE: assert property (
    chord && ctrl_q[8] && code_q == 16'h0 && view.menu == M_DISP
    |=> view.menu == M_PICK)
    else $error("zero code did not open the setpoint menu");
  AST_CHORD_CODE: assert property (
    chord && ctrl_q[8] && code_q != 16'h0 && view.menu == M_DISP
    |=> view.menu == M_CODE)
    else $error("nonzero code did not ask for the code");
  AST_PICK_TOGGLE: assert property (
    view.menu == M_PICK && (btn.up ^ btn.dn) && !btn.sel && !btn.ext
    |=> view.which != $past(view.which))
    else $error("up or down did not switch setpoint item");
  AST_DIGIT_STEP: assert property (
    view.menu inside {M_CODE, M_EDIT} && btn.sel && !btn.up && !btn.dn
    && !btn.ext |=> view.dig == $past(view.dig) + 2'h1)
    else $error("select did not move to the next digit");
  AST_LIMIT_ERR: assert property (
    wr && apb_req.paddr inside {8'h10, 8'h14}
    && apb_req.pwdata[11:0] > 12'hE10 |=> apb_rsp.pslverr)
    else $error("time above the limit was not refused");
  AST_OFF_ONE: assert property (
    (!ctrl_q[0] && $stable(ctrl_q)) [*4] |-> sw[0] == ctrl_q[2])
    else $error("disabled first channel left its idle state");
  AST_OFF_TWO: assert property (
    (!ctrl_q[4] && $stable(ctrl_q)) [*4] |-> sw[1] == ctrl_q[6])
    else $error("disabled second channel left its idle state");
  AST_FLASH_ACT: assert property (
    view.tag == 2'h1 |-> (sw[0] ^ ctrl_q[2]) || alm_q[0])
    else $error("tag shown while output not asserted");
endmodule : alarm_asserts

bind dual_process_alarm alarm_asserts i_chk (
  .clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .btn(btn), .sw(sw), .ann(ann), .view(view)
);

// *** verification/panel_keys.sv ***
module panel_keys
  import dual_process_alarm_pkg::*;
(
  input  wire logic       clk,     // clock
  input  wire btn_t       cmd,     // keys the operator holds
  input  wire logic       go,      // operator acts now
  output btn_t            btn,     // key pulses, registered from cmd
  input  wire logic [1:0] sw,      // switch outputs
  input  wire logic [1:0] nc,      // closed-when-idle choice
  output logic [1:0]      sounding // sounder or beacon on
);
  timeunit 1ns;
  timeprecision 1ps;
  initial btn = '0;
  // a press lasts one cycle; a chord is both keys in that cycle
  always @(posedge clk) begin
    btn <= go ? cmd : '0;
  end
  // sounder sounds when the switch leaves its idle sense
  assign sounding = sw ^ nc;
endmodule : panel_keys

// *** verification/testbench.sv ***
module testbench
  import dual_process_alarm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 10; // short second keeps the waits small
  logic        clk, rst_n, go, err, a0, a1, s1, t1, t2, wh;
  logic [1:0]  sw, ann, snd, d;
  logic [15:0] o, e, c, rd;
  logic [15:0] value;
  apb_req_t    req;
  apb_rsp_t    rsp;
  btn_t        btn, cmd;
  view_t       view;
  int          fail_count, checks_done;
  // display values and the switch pair each must give
  logic [15:0] vt [9] = '{16'h1388, 16'h2327, 16'h2328, 16'h2260,
                          16'h225F, 16'h0065, 16'h0064, 16'h0096, 16'h0097};
  logic [1:0]  st [9] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h2, 2'h0, 2'h0,
                          2'h2};
  dual_process_alarm #(.TICK_CYCLES(TK)) i_dut (.clk(clk), .rst_n(rst_n),
    .apb_req(req), .apb_rsp(rsp), .value(value), .btn(btn), .sw(sw),
    .ann(ann), .view(view));
  panel_keys i_keys (.clk(clk), .cmd(cmd), .go(go), .btn(btn), .sw(sw),
    .nc(2'h2), .sounding(snd));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] ex,
                     input logic [15:0] got);
    checks_done++;
    if (got !== ex) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // one transfer; waits up to 20 cycles for pready
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] dt);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, ad, dt};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rd = rsp.prdata[15:0];
    err = rsp.pslverr;
    req <= '0;
    chk("pready", 16'h1, 16'(rsp.pready));
  endtask : apb
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic press(input btn_t b);
    cmd <= b;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    cyc(3);
  endtask : press
  // gathers what the first channel showed over a span, and both display tags
  task automatic watch(input int n);
    a1 = 1'b0;
    a0 = 1'b0;
    s1 = 1'b0;
    t1 = 1'b0;
    t2 = 1'b0;
    repeat (n) begin
      @(posedge clk);
      a1 |= ann[0];
      a0 |= !ann[0];
      s1 |= sw[0];
      t1 |= view.tag == 2'h1;
      t2 |= view.tag == 2'h2;
    end
  endtask : watch
  function automatic logic [15:0] step(input logic [15:0] v,
                                       input logic [1:0] k);
    logic [15:0] r;
    r = v;
    r[k*4+:4] = r[k*4+:4] + 4'h1;
    return r;
  endfunction : step
  task automatic report_and_stop();
    if (fail_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // a hang would otherwise never end the run
  initial begin
    #400us;
    fail_count++;
    report_and_stop();
  end
  initial begin
    fail_count = 0;
    checks_done = 0;
    rst_n = 1'b0;
    go = 1'b0;
    req = '0;
    cmd = '0;
    value = 16'h1388;
    void'($urandom(32'h4724));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("menu_on", 16'h0, 16'(rd[8]));
    apb(1'b0, 8'h18, 32'h0);
    chk("pass_code", 16'h0, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 16'h1, 16'(err));
    apb(1'b1, 8'h1C, 32'h278D_FF83);
    apb(1'b1, 8'h04, 32'h278E);
    chk("sp_over", 16'h1, 16'(err));
    apb(1'b1, 8'h04, 32'h2328);
    chk("sp_edge", 16'h0, 16'(err));
    apb(1'b1, 8'h10, 32'h0E11 + $urandom_range(16'hF0));
    chk("wait_over", 16'h1, 16'(err));
    apb(1'b1, 8'h14, 32'h0E11_0000);
    chk("quiet_over", 16'h1, 16'(err));
    apb(1'b1, 8'h10, 32'h0E10);
    apb(1'b0, 8'h10, 32'h0);
    chk("wait_max", 16'h0E10, rd);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h08, 32'h0064);
    apb(1'b1, 8'h0C, 32'h0032_00C8);
    apb(1'b1, 8'h00, 32'h005B);
    foreach (vt[i]) begin
      value <= vt[i];
      cyc(4);
      chk("sw", {14'h0, st[i]}, {14'h0, sw});
    end
    value <= 16'h0064;
    apb(1'b1, 8'h00, 32'h004B);
    cyc(4);
    chk("sw_off", 16'h2, {14'h0, sw});
    apb(1'b1, 8'h00, 32'h005B);
    apb(1'b0, 8'h08, 32'h0);
    cyc(4);
    chk("sw_on", 16'h0, {14'h0, sw});
    chk("sounding", 16'h2, {14'h0, snd});
    chk("sp_kept", 16'h0064, rd);
    value <= 16'h1388;
    apb(1'b1, 8'h10, 32'h3);
    value <= 16'h2328;
    watch(16);
    chk("wait_sw", 16'h0, 16'(s1));
    chk("wait_ann", 16'h3, {14'h0, a1, a0});
    chk("wait_tag", 16'h0, 16'(t1));
    value <= 16'h1388;
    cyc(2);
    value <= 16'h2328;
    watch(16);
    chk("restart", 16'h0, 16'(s1));
    cyc(24);
    watch(30);
    chk("act_sw", 16'h1, 16'(sw[0]));
    chk("act_ann", 16'h0, 16'(a0));
    chk("act_tag", 16'h1, 16'(t1));
    press(4'h8);
    chk("no_accept", 16'h1, 16'(sw[0]));
    apb(1'b1, 8'h14, 32'h3);
    press(4'h8);
    watch(16);
    chk("quiet_sw", 16'h0, 16'(s1));
    chk("quiet_ann", 16'h3, {14'h0, a1, a0});
    chk("quiet_tag", 16'h0, 16'(t1));
    cyc(30);
    chk("requiet", 16'h1, 16'(sw[0]));
    press(4'h8);
    value <= 16'h1388;
    cyc(4);
    watch(16);
    chk("clear_ann", 16'h0, 16'(a1));
    press(4'hC);
    chk("chord_off", 16'(M_DISP), 16'(view.menu));
    o = 16'($urandom_range(16'h278D));
    apb(1'b1, 8'h08, {16'h0, o});
    apb(1'b1, 8'h00, 32'h015B);
    press(4'hC);
    chk("chord_open", 16'(M_PICK), 16'(view.menu));
    wh = view.which;
    press(4'h4);
    chk("pick", 16'(!wh), 16'(view.which));
    o = view.which ? o : 16'h2328;
    press(4'h8);
    chk("edit_menu", 16'(M_EDIT), 16'(view.menu));
    chk("edit_load", o, view.edit);
    d = view.dig;
    e = step(o, d);
    press(4'h4);
    chk("edit_step", e, view.edit);
    press(4'h1);
    chk("edit_exit", 16'(M_PICK), 16'(view.menu));
    apb(1'b0, view.which ? 8'h08 : 8'h04, 32'h0);
    chk("edit_store", e <= 16'h278D ? e : o, rd);
    press(4'h1);
    c = 16'($urandom) | 16'h0001;
    apb(1'b1, 8'h18, {16'h0, c});
    press(4'hC);
    chk("code_ask", 16'(M_CODE), 16'(view.menu));
    press(4'h1);
    chk("code_bad", 16'(M_DISP), 16'(view.menu));
    press(4'hC);
    repeat (4) begin
      d = view.dig;
      repeat (4'(c[d*4+:4] - view.edit[d*4+:4])) press(4'h4);
      press(4'h8);
    end
    press(4'h1);
    chk("code_good", 16'(M_PICK), 16'(view.menu));
    press(4'h1);
    // both channels alarmed with the alternate display: tags take turns
    apb(1'b1, 8'h08, 32'h251C);
    apb(1'b1, 8'h00, 32'h00DB);
    value <= 16'h2328;
    cyc(40);
    watch(100);
    chk("both_tag_one", 16'h1, 16'(t1));
    chk("both_tag_two", 16'h1, 16'(t2));
    chk("ann_two", 16'h1, 16'(ann[1]));
    report_and_stop();
  end
endmodule : testbench
